// *** verilog/cam_pkg.sv ***
// Purpose: Constants for the counter array mode control block
// Assumes: APB slave with 32-bit data, 12-bit byte address
// Notes:   Register indices times four give the byte addresses
//
// Summary of operation
// - With idle suspend clear the counter keeps running in CPU idle.
// - With idle suspend set all counter activity halts during CPU idle.
// - Watchdog enable hands module 2 to the watchdog; clear disables it.
// - A set watchdog lock keeps watchdog enable set until system reset.
// - While watchdog enable is 1, writes to the other mode fields are lost.
// - Mode bit 4 reads zero and ignores writes.
// - Select 000 ticks at clock/12, 001 at clock/4, 100 every clock.
// - Select 010 advances the counter on each timer 0 overflow.
// - Select 011 counts falling edges of the count input, at most clock/4.
// - Select 101 counts the synchronised external clock divided by 8.
// - The overflow request is high only with its enable and the flag set.
// - The flag is set by hardware on a wrap to zero, cleared by software.
package cam_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [9:0]  IDX_CTRL   = 10'h0d8;
    localparam logic [9:0]  IDX_MODE   = 10'h0d9;
    localparam logic [9:0]  IDX_COUNT  = 10'h0dc;
    localparam logic [9:0]  IDX_STATUS = 10'h0de;
    localparam logic [9:0]  IDX_MASK   = 10'h0df;
    localparam logic [11:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
    localparam logic [11:0] ADDR_MODE   = {IDX_MODE, 2'b00};
    localparam logic [11:0] ADDR_COUNT  = {IDX_COUNT, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [11:0] ADDR_MASK   = {IDX_MASK, 2'b00};

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int MODE_IDLE   = 7;
    localparam int MODE_WATCHDOG_ENABLE   = 6;
    localparam int MODE_LOCK   = 5;
    localparam int MODE_UNUSED = 4;
    localparam int MODE_SEL_HI = 3;
    localparam int MODE_SEL_LO = 1;
    localparam int MODE_ECF    = 0;
    localparam int CTRL_FLAG   = 7;
    localparam int CTRL_RUN    = 6;
    localparam int EV_OVF      = 0;
    localparam int EV_REFUSED  = 1;
    localparam logic [7:0]  MODE_RESET  = 8'h40;
    localparam logic [7:0]  MODE_OTHERS = 8'h8f;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;
    localparam logic [1:0]  EV_RESET    = 2'h0;

    // ****************************************
    // Timebase codes and divider counts
    // ****************************************
    localparam logic [2:0] SEL_DIV12  = 3'h0;
    localparam logic [2:0] SEL_DIV4   = 3'h1;
    localparam logic [2:0] SEL_TIMER0 = 3'h2;
    localparam logic [2:0] SEL_FALL   = 3'h3;
    localparam logic [2:0] SEL_SYSCLK = 3'h4;
    localparam logic [2:0] SEL_EXT8   = 3'h5;
    localparam logic [3:0] DIV_TWELVE = 4'hc;
    localparam logic [3:0] DIV_FOUR   = 4'h4;
    localparam logic [3:0] DIV_EIGHT  = 4'h8;
endpackage

// *** verilog/cam_edge_if.sv ***
// Purpose: Carries a synchronised pin level and its edges
// Assumes: All signals on clk_sys
// Notes:   Edges are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface cam_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport drv (output level, output rise, output fall);
    modport use_ (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** verilog/cam_sync.sv ***
// Purpose: Two-flop synchroniser with edge detection for a pin
// Assumes: Pin is asynchronous to clk_sys
// Notes:   Edges are taken from the second and third flops only
`timescale 1ns/1ns
`default_nettype none
module cam_sync (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Synchronous reset
    input  wire logic clkEn,     // Clock enable
    input  wire logic pinIn,     // Raw pin
    cam_edge_if.drv   edges      // Level and edges
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Synchroniser chain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else if (clkEn) begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edge decode
    assign edges.level = sync_q;
    assign edges.rise  = clkEn & sync_q & ~last_q;
    assign edges.fall  = clkEn & ~sync_q & last_q;
endmodule
`default_nettype wire

// *** verilog/cam_prescale.sv ***
// Purpose: Divides a stream of increment pulses by a fixed count
// Assumes: DIV between 2 and 15
// Notes:   Tick is combinational, one cycle, on the last increment
`timescale 1ns/1ns
`default_nettype none
module cam_prescale #(
    parameter logic [3:0] DIV = 4'h4
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Synchronous reset
    input  wire logic clkEn,     // Clock enable
    input  wire logic inc,       // Increment pulse
    output logic      tick       // Every DIV-th increment
);
    logic [3:0] cnt_q;
    logic       last;

    // Terminal count
    assign last = (cnt_q == DIV - 4'h1);
    assign tick = clkEn & inc & last;

    // Divider counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 4'h0;
        end else if (clkEn && inc) begin
            cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** verilog/cam_mode_ctrl.sv ***
// Purpose: Mode control and shared 16-bit counter of the counter array
// Assumes: APB master on clk_sys; idle and timer 0 inputs on clk_sys
// Notes:   Reset acts regardless of clock enable
`timescale 1ns/1ns
`default_nettype none
module cam_mode_ctrl (
    input  wire logic         clk_sys,        // System clock, 25 MHz
    input  wire logic         rst,            // Synchronous reset
    input  wire logic         clkEn,          // Clock enable
    input  wire logic         psel,           // APB select
    input  wire logic         penable,        // APB enable
    input  wire logic         pwrite,         // APB direction
    input  wire logic [11:0]  paddr,          // APB byte address
    input  wire logic [31:0]  pwdata,         // APB write data
    output logic      [31:0]  prdata,         // APB read data
    output logic              pready,         // APB ready
    output logic              pslverr,        // APB error
    input  wire logic         cpuIdle,        // CPU in idle state
    input  wire logic         timer0Overflow, // Timer 0 overflow pulse
    input  wire logic         extCountPin,    // External count input pin
    input  wire logic         extClockPin,    // External clock pin
    output logic              watchdogActive, // Module 2 is the watchdog
    output logic      [15:0]  counterValue,   // Counter value
    output logic              overflowIrq,    // Overflow request
    output logic              irq             // Masked status interrupt
);
    import cam_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic        run_q;
    logic        flag_q;
    logic        flag_d;
    logic [15:0] count_q;
    logic [1:0]  status_q;
    logic [1:0]  status_d;
    logic [1:0]  mask_q;
    logic        irq_q;
    logic        ovfIrq_q;
    logic [31:0] rdata_q;
    logic        rdy_q;

    // ****************************************
    // Bus decode
    // ****************************************
    logic        setupPh;
    logic        accessDone;
    logic        wrDone;
    logic        hitCtrl;
    logic        hitMode;
    logic        hitCount;
    logic        hitStatus;
    logic        hitMask;
    logic        hitAny;
    logic [31:0] readMux;

    // Address match and phases
    assign hitCtrl    = (paddr == ADDR_CTRL);
    assign hitMode    = (paddr == ADDR_MODE);
    assign hitCount   = (paddr == ADDR_COUNT);
    assign hitStatus  = (paddr == ADDR_STATUS);
    assign hitMask    = (paddr == ADDR_MASK);
    assign hitAny     = hitCtrl | hitMode | hitCount | hitStatus | hitMask;
    assign setupPh    = clkEn & psel & ~rdy_q;
    assign pready     = clkEn & rdy_q & penable;
    assign accessDone = psel & penable & pready;
    assign wrDone     = accessDone & pwrite & hitAny;
    assign pslverr    = pready & ~hitAny;
    assign prdata     = rdata_q;

    // Read selection
    assign readMux = hitCtrl   ? {24'h0, flag_q, run_q, 6'h0} :
                     hitMode   ? {24'h0, mode_q} :
                     hitCount  ? {16'h0, count_q} :
                     hitStatus ? {30'h0, status_q} :
                     hitMask   ? {30'h0, mask_q} : 32'h0;

    // Read capture in setup, ready in access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdy_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else if (accessDone) begin
            rdy_q   <= 1'b0;
        end else if (setupPh) begin
            rdy_q   <= 1'b1;
            rdata_q <= pwrite ? 32'h0 : readMux;
        end
    end

    // ****************************************
    // Mode register
    // ****************************************
    logic       modeWr;
    logic       watchdog_enable;
    logic       locked;
    logic       wdteNext;
    logic [7:0] othersNext;
    logic       refused;
    logic [2:0] sel;
    logic       idleSuspend;
    logic       ecf;

    assign modeWr      = wrDone & hitMode;
    assign watchdog_enable        = mode_q[MODE_WATCHDOG_ENABLE];
    assign locked      = mode_q[MODE_LOCK];
    assign sel         = mode_q[MODE_SEL_HI:MODE_SEL_LO];
    assign idleSuspend = mode_q[MODE_IDLE];
    assign ecf         = mode_q[MODE_ECF];
    assign wdteNext    = locked | pwdata[MODE_WATCHDOG_ENABLE];
    assign othersNext  = watchdog_enable ? (mode_q & MODE_OTHERS)
                              : (pwdata[7:0] & MODE_OTHERS);
    assign refused     = modeWr & watchdog_enable
                       & ((pwdata[7:0] & MODE_OTHERS) != (mode_q & MODE_OTHERS));

    // Next mode value; lock only sets and only from disabled state
    always_comb begin
        mode_d = mode_q;
        if (modeWr) begin
            mode_d = othersNext;
            mode_d[MODE_WATCHDOG_ENABLE] = wdteNext;
            mode_d[MODE_LOCK] = locked | (~watchdog_enable & pwdata[MODE_LOCK]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_q <= MODE_RESET;
        end else if (clkEn) begin
            mode_q <= mode_d;
        end
    end

    assign watchdogActive = watchdog_enable;

    // ****************************************
    // Timebase selection
    // ****************************************
    logic halted;
    logic active;
    logic tick12;
    logic tick4;
    logic tick8;
    logic tickSel;

    cam_edge_if countEdges ();
    cam_edge_if clockEdges ();

    assign halted = cpuIdle & idleSuspend;
    assign active = clkEn & run_q & ~halted;

    // Pin synchronisers
    cam_sync u_countSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .pinIn   (extCountPin),
        .edges   (countEdges)
    );
    cam_sync u_clockSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .pinIn   (extClockPin),
        .edges   (clockEdges)
    );

    // Dividers
    cam_prescale #(.DIV(DIV_TWELVE)) u_div12 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .inc     (active),
        .tick    (tick12)
    );
    cam_prescale #(.DIV(DIV_FOUR)) u_div4 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .inc     (active),
        .tick    (tick4)
    );
    cam_prescale #(.DIV(DIV_EIGHT)) u_div8 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .inc     (active & clockEdges.rise),
        .tick    (tick8)
    );

    always_comb begin
        case (sel)
            SEL_DIV12:  tickSel = tick12;
            SEL_DIV4:   tickSel = tick4;
            SEL_TIMER0: tickSel = timer0Overflow;
            SEL_FALL:   tickSel = countEdges.fall;
            SEL_SYSCLK: tickSel = 1'b1;
            SEL_EXT8:   tickSel = tick8;
            default:    tickSel = 1'b0;
        endcase
    end

    // ****************************************
    // Counter, flag and run control
    // ****************************************
    logic countInc;
    logic wrap;
    logic ctrlWr;

    assign countInc     = active & tickSel;
    assign wrap         = countInc & (count_q == COUNT_MAX);
    assign ctrlWr       = wrDone & hitCtrl;
    assign counterValue = count_q;
    assign flag_d = wrap | (ctrlWr ? pwdata[CTRL_FLAG] : flag_q);

    // Counter and control bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= 16'h0;
            flag_q  <= 1'b0;
            run_q   <= 1'b0;
        end else if (clkEn) begin
            count_q <= countInc ? count_q + 16'h1 : count_q;
            flag_q  <= flag_d;
            run_q   <= ctrlWr ? pwdata[CTRL_RUN] : run_q;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [1:0] events;
    logic [1:0] stsClr;

    assign events = {refused, wrap};
    assign stsClr = (accessDone & ~pwrite & hitStatus) ? rdata_q[1:0] : 2'h0;
    assign status_d = events | (status_q & ~stsClr);
    assign overflowIrq = ovfIrq_q;
    assign irq = irq_q;

    // Status, mask and request flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_q <= EV_RESET;
            mask_q   <= EV_RESET;
            irq_q    <= 1'b0;
            ovfIrq_q <= 1'b0;
        end else if (clkEn) begin
            status_q <= status_d;
            mask_q   <= (wrDone & hitMask) ? pwdata[1:0] : mask_q;
            irq_q    <= |(status_d & mask_q);
            ovfIrq_q <= mode_d[MODE_ECF] & flag_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_idle_keeps_run: assert property (
        (countInc && !idleSuspend && cpuIdle && count_q != COUNT_MAX)
        |=> count_q == $past(count_q) + 16'h1)
        else $error("counter stalled in idle without suspend");
    a_idle_halts: assert property (
        (idleSuspend && cpuIdle) |=> $stable(count_q))
        else $error("counter moved during suspended idle");
    a_wdog_enable: assert property (
        (clkEn && modeWr && !pwdata[MODE_WATCHDOG_ENABLE] && !locked)
        |=> !watchdogActive)
        else $error("watchdog not released by clearing write");
    a_lock_holds: assert property (
        (locked && watchdog_enable) |=> (locked && watchdogActive))
        else $error("locked watchdog was disabled");
    a_fields_frozen: assert property (
        (watchdog_enable && modeWr)
        |=> (mode_q & MODE_OTHERS) == $past(mode_q & MODE_OTHERS))
        else $error("mode field changed while watchdog enabled");
    a_unused_zero: assert property (
        (accessDone && !pwrite && hitMode)
        |-> (prdata[MODE_UNUSED] == 1'b0 && prdata[31:8] == 24'h0))
        else $error("unused mode bit read nonzero");
    a_sysclk_tick: assert property (
        (sel == SEL_SYSCLK && active) |-> countInc)
        else $error("undivided timebase missed a cycle");
    a_div_spacing: assert property (
        (sel == SEL_DIV4 && countInc && clkEn && !cpuIdle)
        ##1 (sel == SEL_DIV4 && active)[*3] |-> !$past(countInc))
        else $error("divide by four ticked early");
    a_timer0_tick: assert property (
        (sel == SEL_TIMER0 && active) |-> (countInc == timer0Overflow))
        else $error("timer 0 overflow not followed");
    a_fall_count: assert property (
        (sel == SEL_FALL && active) |-> (countInc == countEdges.fall))
        else $error("count input edge not followed");
    a_ext_divided: assert property (
        (sel == SEL_EXT8 && active) |-> (countInc == tick8))
        else $error("external divided clock not followed");
    a_irq_request: assert property (
        clkEn ##1 overflowIrq |-> $past(mode_d[MODE_ECF] && flag_d))
        else $error("overflow request without cause");
    a_irq_masked: assert property (
        (clkEn && !mode_d[MODE_ECF]) |=> !overflowIrq)
        else $error("overflow request while disabled");
    a_wrap_flag: assert property (
        wrap |=> (flag_q && count_q == 16'h0 && status_q[EV_OVF]))
        else $error("wrap did not set the flag");
    a_flag_clear: assert property (
        (ctrlWr && !pwdata[CTRL_FLAG] && !wrap) |=> !flag_q)
        else $error("software clear of the flag lost");
    a_refused_event: assert property (
        refused |=> status_q[EV_REFUSED])
        else $error("refused mode write not reported");
    a_ready_in_access: assert property (
        pready |-> (psel && penable))
        else $error("ready outside an access phase");
    a_reset_mode: assert property (
        @(posedge clk_sys) $fell(rst) |-> mode_q == MODE_RESET)
        else $error("mode reset value wrong");
    a_reserved_idle: assert property (
        (sel[2:1] == 2'b11) |-> !countInc)
        else $error("reserved timebase advanced counter");

    c_wrap_seen:   cover property (wrap);
    c_lock_set:    cover property (locked && watchdog_enable);
    c_refused_wr:  cover property (refused);
    c_idle_halt:   cover property (halted && run_q);
    c_ext_tick:    cover property (sel == SEL_EXT8 && countInc);
endmodule
`default_nettype wire

// *** test/cam_mode_ctrl_tb.sv ***
// Purpose: Self-checking bench for the counter array mode control
// Assumes: APB answers within 50 cycles; clkEn low only in its own test
// Notes:   Counts are taken as deltas between two reads 96 cycles apart
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cam_pkg::*;
    typedef struct {
        logic [7:0]  mode;
        logic        idle;
        logic [31:0] delta;
    } cam_row_s;

    // ****************************************
    // Signals
    // ****************************************
    logic        clk_sys        = 1'b0;
    logic        rst            = 1'b1;
    logic        clkEn          = 1'b1;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [11:0] paddr          = 12'h000;
    logic [31:0] pwdata         = 32'h0;
    logic        cpuIdle        = 1'b0;
    logic        timer0Overflow = 1'b0;
    logic        extCountPin    = 1'b1;
    logic        extClockPin    = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        watchdogActive;
    logic [15:0] counterValue;
    logic        overflowIrq;
    logic        irq;
    logic [31:0] cyc            = 32'h0;
    logic [31:0] rv;
    logic [31:0] c0;
    logic        ev;
    int          errorCnt       = 0;
    int          samplesChecked = 0;
    int          n;
    cam_row_s    rows [11];

    cam_mode_ctrl dut_u (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .clkEn          (clkEn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .cpuIdle        (cpuIdle),
        .timer0Overflow (timer0Overflow),
        .extCountPin    (extCountPin),
        .extClockPin    (extClockPin),
        .watchdogActive (watchdogActive),
        .counterValue   (counterValue),
        .overflowIrq    (overflowIrq),
        .irq            (irq)
    );

    // Clock at 25 MHz
    always #20 clk_sys = ~clk_sys;

    // Periodic event sources: timer 0 every 8, falls every 16, rises every 4
    // Count input toggles far below clock/4
    always @(posedge clk_sys) begin
        cyc            <= cyc + 32'h1;
        timer0Overflow <= (cyc[2:0] == 3'h0);
        extCountPin    <= cyc[3];
        extClockPin    <= cyc[1];
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            errorCnt++;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic tally_and_finish;
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk_sys);
        errorCnt++;
        tally_and_finish;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        // Mode byte, idle level, expected advance in 96 cycles
        rows = '{'{8'h00, 1'b0, 32'd8}, '{8'h02, 1'b0, 32'd24},
                 '{8'h08, 1'b0, 32'd96}, '{8'h04, 1'b0, 32'd12},
                 '{8'h06, 1'b0, 32'd6}, '{8'h0a, 1'b0, 32'd3},
                 '{8'h0c, 1'b0, 32'd0}, '{8'h0e, 1'b0, 32'd0},
                 '{8'h08, 1'b1, 32'd96}, '{8'h88, 1'b1, 32'd0},
                 '{8'h88, 1'b0, 32'd96}};
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(ADDR_MODE, 32'h40);
        rdc(ADDR_CTRL, 32'h0);
        rdc(ADDR_COUNT, 32'h0);
        chk({16'h0, counterValue}, 32'h0);
        chk({31'h0, watchdogActive}, 32'h1);
        chk({30'h0, overflowIrq, irq}, 32'h0);
        // Enable written as 1 stays; the other fields are refused
        wr(ADDR_MODE, 8'hdf);
        rdc(ADDR_MODE, 32'h40);
        rdc(ADDR_STATUS, 32'h2);
        wr(ADDR_MODE, 8'h00);
        rdc(ADDR_MODE, 32'h0);
        chk({31'h0, watchdogActive}, 32'h0);
        wr(ADDR_MODE, 8'h10);
        rdc(ADDR_MODE, 32'h0);
        apb(1'b0, 12'h000, 32'h0, rv, ev);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        // Timebase and idle table
        wr(ADDR_CTRL, 8'h40);
        foreach (rows[i]) begin
            cpuIdle <= rows[i].idle;
            wr(ADDR_MODE, rows[i].mode);
            apb(1'b0, ADDR_COUNT, 32'h0, c0, ev);
            repeat (93) @(posedge clk_sys);
            apb(1'b0, ADDR_COUNT, 32'h0, rv, ev);
            rv = {16'h0, rv[15:0] - c0[15:0]};
            chk(rv, rows[i].delta);
        end
        cpuIdle <= 1'b0;
        // Wrap of the counter and the requests it raises
        apb(1'b0, ADDR_STATUS, 32'h0, rv, ev);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_MODE, 8'h09);
        n = 0;
        while (overflowIrq !== 1'b1 && n < 70000) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, overflowIrq}, 32'h1);
        rdc(ADDR_CTRL, 32'hc0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        rdc(ADDR_STATUS, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_MODE, 8'h08);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, overflowIrq}, 32'h0);
        wr(ADDR_MODE, 8'h09);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, overflowIrq}, 32'h1);
        wr(ADDR_CTRL, 8'h40);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, overflowIrq}, 32'h0);
        // Clock enable low freezes the running counter
        clkEn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        c0 = {16'h0, counterValue};
        repeat (10) @(posedge clk_sys);
        chk({16'h0, counterValue}, c0);
        clkEn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({16'h0, counterValue}, c0 + 32'h1);
        // Lock holds the watchdog on; refused event stays masked
        wr(ADDR_MODE, 8'h60);
        wr(ADDR_MODE, 8'h00);
        rdc(ADDR_MODE, 32'h60);
        wr(ADDR_MODE, 8'h4f);
        rdc(ADDR_MODE, 32'h60);
        chk({31'h0, watchdogActive}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rdc(ADDR_STATUS, 32'h2);
        // Reset in mid-run releases the lock
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(ADDR_MODE, 32'h40);
        chk({31'h0, watchdogActive}, 32'h1);
        wr(ADDR_MODE, 8'h00);
        rdc(ADDR_MODE, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
